// ### include/serial_flash_read_defs.svh
// Constants for the serial flash read engine
// Operation
// - Sample on rising clock, drive on falling
// - Any start byte; address increments, wraps zero
// - Fast read: opcode, 3 address bytes, dummy byte
// - Raising chip select ends read, stops output
// - Busy device rejects reads, internal cycle untouched
// - Dual output: 8 dummy clocks, two-bit data
// - Dual I/O: two-bit address, 4 dummy clocks
// - Decode BB dual I/O, 6B quad output
// - Quad output: 8 dummy clocks, four-bit data
// - Quad I/O needs quad enable bit set
// - Quad I/O: four-bit address, 2+4 dummy clocks
// - Continuous quad: next frame starts with address
// - Toggling indicator nibbles keep continuous mode
// - Non-toggling indicator leaves mode after frame
// - Burst command C0: nibble 0 enables, 1 disables
// - Depth code 0..3 gives 8..64 byte wrap
// - Wrap stays inside aligned window of page
// - Wrap off at reset, kept until changed
// - Quad I/O read honours wrap setting
// - Continuous mode only on quad I/O read
// - FFh on line zero forces continuous exit
`ifndef SERIAL_FLASH_READ_DEFS_SVH
`define SERIAL_FLASH_READ_DEFS_SVH

`define OP_FAST_READ    8'h0B
`define OP_DUAL_OUT     8'h3B
`define OP_DUAL_IO      8'hBB
`define OP_QUAD_OUT     8'h6B
`define OP_QUAD_IO      8'hEB
`define OP_BURST_LEN    8'hC0

`define FLASH_ADDR_W    22
`define OPCODE_LAST     5'd7
`define ADDR_LAST_X1    5'd23
`define ADDR_LAST_X2    5'd11
`define ADDR_LAST_X4    5'd5
`define DUMMY_LAST_LONG 5'd7
`define DUMMY_LAST_SHRT 5'd3
`define MODE_LAST       5'd1

`define WRAP_ON_NIBBLE  4'h0
`define WRAP_OFF_NIBBLE 4'h1
`define WRAP_MASK_8     8'h07
`define WRAP_MASK_16    8'h0F
`define WRAP_MASK_32    8'h1F
`define WRAP_MASK_64    8'h3F

`endif

// ### include/flash_read_pkg.sv
// Types of the serial flash read engine
`default_nettype none
package flash_read_pkg;

	typedef enum logic [2:0] {
		ph_cmd,
		ph_addr,
		ph_mode,
		ph_dummy,
		ph_data,
		ph_burst,
		ph_ignore
	} phase_e;

	typedef enum logic [2:0] {
		c_fast,
		c_dout,
		c_dio,
		c_qout,
		c_qio
	} cmd_e;

endpackage
`default_nettype wire

// ### logic/serial_flash_read_engine.sv
// Read command engine of a serial multi-line flash
`timescale 1ns/100ps
`default_nettype none
`include "serial_flash_read_defs.svh"
module serial_flash_read_engine #(
	parameter int ADDR_W = `FLASH_ADDR_W
) (
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic              busy,
	input  wire logic              quad_enable_bit,
	input  wire logic              serial_clk,
	input  wire logic              cs_n,
	input  wire logic [3:0]        data_line_in,
	output var  logic [3:0]        data_line_out,
	output var  logic [3:0]        data_line_oe,
	output var  logic [ADDR_W-1:0] mem_addr,
	output var  logic              mem_rd,
	input  wire logic [7:0]        mem_rdata,
	output var  logic              cont_mode_flag,
	output var  logic              wrap_enabled_flag
);

	flash_read_pkg::phase_e phase;
	flash_read_pkg::cmd_e   cmd, eff_cmd;
	logic [4:0]             cnt;
	logic [7:0]             op_sh, out_sh, fetch_data, op_byte, mode_byte;
	logic [23:0]            addr_sh, addr_next;
	logic [3:0]             mode_hi;
	logic [2:0]             data_w;
	logic [1:0]             wrap_depth;
	logic [ADDR_W-1:0]      fetch_addr;
	logic                   all_ones, cont_frame, cont_mode, wrap_en;
	logic                   rst_q, lrst_s1, link_rst_n;
	logic                   busy_s1, busy_s2, qe_s1, qe_s2;
	logic                   req_tog, req_s1, req_s2, req_s3, rd_q, cont_s1, wrap_s1;
	logic                   in_addr, addr_done, dummy_done, byte_done, mode_done;
	logic                   force_exit, cont_set, cont_clr, burst_done, read_ok;

	function automatic logic [2:0] lane_w(
		input flash_read_pkg::cmd_e c,
		input logic                 addr_phase
	);
		unique case (c)
			flash_read_pkg::c_fast: lane_w = 3'd1;
			flash_read_pkg::c_dout: lane_w = addr_phase ? 3'd1 : 3'd2;
			flash_read_pkg::c_dio:  lane_w = 3'd2;
			flash_read_pkg::c_qout: lane_w = addr_phase ? 3'd1 : 3'd4;
			flash_read_pkg::c_qio:  lane_w = 3'd4;
			default:                lane_w = 3'd1;
		endcase
	endfunction
	function automatic logic [4:0] addr_last(input flash_read_pkg::cmd_e c);
		unique case (c)
			flash_read_pkg::c_dio: addr_last = `ADDR_LAST_X2;
			flash_read_pkg::c_qio: addr_last = `ADDR_LAST_X4;
			default:               addr_last = `ADDR_LAST_X1;
		endcase
	endfunction
	function automatic logic [4:0] dummy_last(input flash_read_pkg::cmd_e c);
		unique case (c)
			flash_read_pkg::c_dio: dummy_last = `DUMMY_LAST_SHRT;
			flash_read_pkg::c_qio: dummy_last = `DUMMY_LAST_SHRT;
			default:               dummy_last = `DUMMY_LAST_LONG;
		endcase
	endfunction
	function automatic logic [4:0] data_last(input logic [2:0] w);
		unique case (w)
			3'd1:    data_last = 5'd7;
			3'd2:    data_last = 5'd3;
			default: data_last = 5'd1;
		endcase
	endfunction
	function automatic logic [23:0] shift_in(
		input logic [23:0] v,
		input logic [3:0]  d,
		input logic [2:0]  w
	);
		unique case (w)
			3'd1:    shift_in = {v[22:0], d[0]};
			3'd2:    shift_in = {v[21:0], d[1:0]};
			default: shift_in = {v[19:0], d};
		endcase
	endfunction
	function automatic logic [7:0] shl(
		input logic [7:0] v,
		input logic [2:0] w
	);
		unique case (w)
			3'd1:    shl = {v[6:0], 1'b0};
			3'd2:    shl = {v[5:0], 2'b00};
			default: shl = {v[3:0], 4'h0};
		endcase
	endfunction
	function automatic logic [7:0] wrap_mask(input logic [1:0] depth);
		unique case (depth)
			2'd0: wrap_mask = `WRAP_MASK_8;
			2'd1: wrap_mask = `WRAP_MASK_16;
			2'd2: wrap_mask = `WRAP_MASK_32;
			2'd3: wrap_mask = `WRAP_MASK_64;
		endcase
	endfunction
	function automatic logic [ADDR_W-1:0] step_addr(
		input logic [ADDR_W-1:0] a,
		input logic              wrap,
		input logic [1:0]        depth
	);
		logic [ADDR_W-1:0] m;
		logic [ADDR_W-1:0] inc;
		m = ADDR_W'(wrap_mask(depth));
		inc = a + 1'b1;
		if (wrap) begin
			step_addr = (a & ~m) | (inc & m);
		end else begin
			step_addr = inc;
		end
	endfunction
	function automatic flash_read_pkg::cmd_e to_cmd(input logic [7:0] op);
		case (op)
			`OP_DUAL_OUT: to_cmd = flash_read_pkg::c_dout;
			`OP_DUAL_IO:  to_cmd = flash_read_pkg::c_dio;
			`OP_QUAD_OUT: to_cmd = flash_read_pkg::c_qout;
			`OP_QUAD_IO:  to_cmd = flash_read_pkg::c_qio;
			default:      to_cmd = flash_read_pkg::c_fast;
		endcase
	endfunction
	function automatic logic is_read(input logic [7:0] op);
		case (op)
			`OP_FAST_READ, `OP_DUAL_OUT:            is_read = 1'b1;
			`OP_DUAL_IO, `OP_QUAD_OUT, `OP_QUAD_IO: is_read = 1'b1;
			default:                                is_read = 1'b0;
		endcase
	endfunction

	// Frame decode events
	always_comb begin
		op_byte = {op_sh[6:0], data_line_in[0]};
		in_addr = (phase == flash_read_pkg::ph_addr) ||
			((phase == flash_read_pkg::ph_cmd) && cont_mode);
		eff_cmd = in_addr && (phase == flash_read_pkg::ph_cmd) ?
			flash_read_pkg::c_qio : cmd;
		addr_next = shift_in(addr_sh, data_line_in, lane_w(eff_cmd, 1'b1));
		addr_done = in_addr && (cnt == addr_last(eff_cmd));
		mode_byte = {mode_hi, data_line_in};
		data_w = lane_w(cmd, 1'b0);
		dummy_done = (phase == flash_read_pkg::ph_dummy) && (cnt == dummy_last(cmd));
		byte_done = (phase == flash_read_pkg::ph_data) && (cnt == data_last(data_w));
		mode_done = (phase == flash_read_pkg::ph_mode) && (cnt == `MODE_LAST);
		force_exit = mode_done && cont_frame && all_ones && data_line_in[0];
		cont_set = mode_done && !force_exit &&
			((mode_byte[7:4] ^ mode_byte[3:0]) == 4'hF);
		cont_clr = mode_done && !cont_set;
		burst_done = (phase == flash_read_pkg::ph_burst) && (cnt == `OPCODE_LAST);
		read_ok = is_read(op_byte) && !busy_s2 &&
			((op_byte != `OP_QUAD_IO) || qe_s2);
	end

	// Command, address, dummy and data sequencing on rising edges
	always_ff @(posedge serial_clk or posedge cs_n) begin
		if (cs_n) begin
			phase <= flash_read_pkg::ph_cmd;
			cmd <= flash_read_pkg::c_fast;
			cnt <= 5'd0;
			op_sh <= 8'h00;
			addr_sh <= 24'h000000;
			mode_hi <= 4'h0;
			all_ones <= 1'b1;
			cont_frame <= 1'b0;
			out_sh <= 8'h00;
		end else if (in_addr) begin
			addr_sh <= addr_next;
			cmd <= eff_cmd;
			all_ones <= all_ones & data_line_in[0];
			if (phase == flash_read_pkg::ph_cmd) begin
				cont_frame <= 1'b1;
			end
			if (addr_done) begin
				cnt <= 5'd0;
				if (eff_cmd == flash_read_pkg::c_qio) begin
					phase <= flash_read_pkg::ph_mode;
				end else begin
					phase <= flash_read_pkg::ph_dummy;
				end
			end else begin
				cnt <= cnt + 5'd1;
				phase <= flash_read_pkg::ph_addr;
			end
		end else begin
			unique case (phase)
				flash_read_pkg::ph_cmd: begin
					op_sh <= op_byte;
					if (cnt == `OPCODE_LAST) begin
						cnt <= 5'd0;
						if (read_ok) begin
							cmd <= to_cmd(op_byte);
							phase <= flash_read_pkg::ph_addr;
						end else if (op_byte == `OP_BURST_LEN) begin
							phase <= flash_read_pkg::ph_burst;
						end else begin
							phase <= flash_read_pkg::ph_ignore;
						end
					end else begin
						cnt <= cnt + 5'd1;
					end
				end
				flash_read_pkg::ph_mode: begin
					all_ones <= all_ones & data_line_in[0];
					if (mode_done) begin
						cnt <= 5'd0;
						if (force_exit) begin
							phase <= flash_read_pkg::ph_ignore;
						end else begin
							phase <= flash_read_pkg::ph_dummy;
						end
					end else begin
						mode_hi <= data_line_in;
						cnt <= cnt + 5'd1;
					end
				end
				flash_read_pkg::ph_dummy: begin
					if (dummy_done) begin
						cnt <= 5'd0;
						out_sh <= fetch_data;
						phase <= flash_read_pkg::ph_data;
					end else begin
						cnt <= cnt + 5'd1;
					end
				end
				flash_read_pkg::ph_data: begin
					if (byte_done) begin
						cnt <= 5'd0;
						out_sh <= fetch_data;
					end else begin
						cnt <= cnt + 5'd1;
						out_sh <= shl(out_sh, data_w);
					end
				end
				flash_read_pkg::ph_burst: begin
					op_sh <= op_byte;
					if (burst_done) begin
						phase <= flash_read_pkg::ph_ignore;
					end else begin
						cnt <= cnt + 5'd1;
					end
				end
				flash_read_pkg::ph_ignore: begin
					cnt <= 5'd0;
				end
			endcase
		end
	end

	// Output lanes change on falling edges
	always_ff @(negedge serial_clk or posedge cs_n) begin
		if (cs_n) begin
			data_line_out <= 4'h0;
			data_line_oe <= 4'h0;
		end else if (phase == flash_read_pkg::ph_data) begin
			unique case (data_w)
				3'd1: begin
					data_line_out <= {2'b00, out_sh[7], 1'b0};
					data_line_oe <= 4'h2;
				end
				3'd2: begin
					data_line_out <= {2'b00, out_sh[7:6]};
					data_line_oe <= 4'h3;
				end
				default: begin
					data_line_out <= out_sh[7:4];
					data_line_oe <= 4'hF;
				end
			endcase
		end else begin
			data_line_out <= 4'h0;
			data_line_oe <= 4'h0;
		end
	end

	// Link reset: asserted one system clock edge after resetn, released on serial clock edges
	always_ff @(posedge ref_clk) begin
		rst_q <= resetn;
	end

	always_ff @(posedge serial_clk or negedge rst_q) begin
		if (!rst_q) begin
			lrst_s1 <= 1'b0;
			link_rst_n <= 1'b0;
		end else begin
			lrst_s1 <= 1'b1;
			link_rst_n <= lrst_s1;
		end
	end

	// Status levels into the link domain
	always_ff @(posedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			busy_s1 <= 1'b0;
			busy_s2 <= 1'b0;
			qe_s1 <= 1'b0;
			qe_s2 <= 1'b0;
		end else begin
			busy_s1 <= busy;
			busy_s2 <= busy_s1;
			qe_s1 <= quad_enable_bit;
			qe_s2 <= qe_s1;
		end
	end

	// Continuous quad mode, kept across frames
	always_ff @(posedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cont_mode <= 1'b0;
		end else if (cont_set && (cmd == flash_read_pkg::c_qio)) begin
			cont_mode <= 1'b1;
		end else if (cont_clr || force_exit) begin
			cont_mode <= 1'b0;
		end
	end

	// Wrap setting from the burst length command
	always_ff @(posedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			wrap_en <= 1'b0;
			wrap_depth <= 2'd0;
		end else if (burst_done) begin
			if ((op_byte[7:4] == `WRAP_ON_NIBBLE) && (op_byte[3:2] == 2'b00)) begin
				wrap_en <= 1'b1;
				wrap_depth <= op_byte[1:0];
			end else if (op_byte[7:4] == `WRAP_OFF_NIBBLE) begin
				wrap_en <= 1'b0;
			end
		end
	end

	// Prefetch address and request toggle
	always_ff @(posedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			fetch_addr <= '0;
			req_tog <= 1'b0;
		end else if (addr_done) begin
			fetch_addr <= addr_next[ADDR_W-1:0];
			req_tog <= ~req_tog;
		end else if (dummy_done || byte_done) begin
			fetch_addr <= step_addr(fetch_addr,
				wrap_en && (cmd == flash_read_pkg::c_qio), wrap_depth);
			req_tog <= ~req_tog;
		end
	end

	// Array fetch in the system clock domain
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end else begin
			req_s1 <= req_tog;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			mem_rd <= 1'b0;
			mem_addr <= '0;
		end else begin
			mem_rd <= req_s2 ^ req_s3;
			if (req_s2 ^ req_s3) begin
				mem_addr <= fetch_addr;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rd_q <= 1'b0;
			fetch_data <= 8'h00;
		end else begin
			rd_q <= mem_rd;
			if (rd_q) begin
				fetch_data <= mem_rdata;
			end
		end
	end

	// Mode status back to the system side
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cont_s1 <= 1'b0;
			cont_mode_flag <= 1'b0;
			wrap_s1 <= 1'b0;
			wrap_enabled_flag <= 1'b0;
		end else begin
			cont_s1 <= cont_mode;
			cont_mode_flag <= cont_s1;
			wrap_s1 <= wrap_en;
			wrap_enabled_flag <= wrap_s1;
		end
	end

endmodule
`default_nettype wire

// ### verif/flash_read_checker_assertions.sv
// Assertion checker of the serial flash read engine
`timescale 1ns/100ps
`default_nettype none
module flash_read_checker #(
	parameter int ADDR_W = 22
) (
	input wire logic              ref_clk,
	input wire logic              resetn,
	input wire logic              serial_clk,
	input wire logic              cs_n,
	input wire logic [3:0]        data_line_out,
	input wire logic [3:0]        data_line_oe,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic              mem_rd,
	input wire logic              quad_enable_bit,
	input wire logic              cont_mode_flag,
	input wire logic              wrap_enabled_flag
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	logic [ADDR_W-1:0] prev_addr;
	logic              prev_ok;

	// Last array fetch of the open frame
	always_ff @(posedge ref_clk) begin
		if (!resetn || cs_n) begin
			prev_ok <= 1'b0;
		end else if (mem_rd) begin
			prev_ok <= 1'b1;
		end
		if (mem_rd) begin
			prev_addr <= mem_addr;
		end
	end

	// Array fetch inside a frame
	sequence frame_fetch;
		mem_rd && !cs_n;
	endsequence

	property addr_step;
		(prev_ok && !wrap_enabled_flag) ##0 frame_fetch |-> mem_addr == prev_addr + 1'b1;
	endproperty

	oe_idle_a: assert property (cs_n |-> data_line_oe == 4'h0)
		else $error("line driven while deselected");
	oe_lanes_a: assert property (data_line_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("illegal lane enable pattern");
	out_fall_a: assert property (!cs_n && $past(!cs_n) && $changed(data_line_out)
		|-> !serial_clk)
		else $error("output changed outside falling edge");
	out_hold_a: assert property (!cs_n && $changed(data_line_out)
		|=> ($stable(data_line_out) || cs_n)[*8])
		else $error("output group too short");
	fetch_space_a: assert property (mem_rd |=> (!mem_rd)[*8])
		else $error("array fetches too close");
	addr_step_a: assert property (addr_step)
		else $error("address did not advance by one");
	cont_qe_a: assert property ($rose(cont_mode_flag) |-> quad_enable_bit)
		else $error("continuous mode without quad enable");
	reset_clear_a: assert property (disable iff (1'b0) !resetn[*3]
		|-> !mem_rd && !cont_mode_flag && !wrap_enabled_flag)
		else $error("state not cleared by reset");
endmodule
bind serial_flash_read_engine flash_read_checker #(.ADDR_W(ADDR_W)) u_checker (
	.ref_clk(ref_clk), .resetn(resetn), .serial_clk(serial_clk), .cs_n(cs_n),
	.data_line_out(data_line_out), .data_line_oe(data_line_oe), .mem_addr(mem_addr),
	.mem_rd(mem_rd), .quad_enable_bit(quad_enable_bit), .cont_mode_flag(cont_mode_flag),
	.wrap_enabled_flag(wrap_enabled_flag)
);
`default_nettype wire

// ### verif/flash_host.sv
// Host controller model driving the serial flash link
`timescale 1ns/100ps
`default_nettype none
module flash_host (
	output logic            serial_clk,
	output logic            cs_n,
	output logic [3:0]      host_drive,
	input  wire logic [3:0] line_level
);
	logic [7:0] got[$];
	logic [3:0] smp;
	initial begin
		serial_clk = 1'b0;
		cs_n = 1'b1;
		host_drive = 4'h0;
	end
	// One clock: drive, sample on rise, clock idles low
	task automatic pulse(input logic [3:0] v);
		host_drive = v;
		#32 serial_clk = 1'b1;
		smp = line_level;
		#32 serial_clk = 1'b0;
	endtask
	task automatic shift(input logic [23:0] v, input int bits, input int w);
		for (int i = bits - w; i >= 0; i -= w)
			pulse(4'((v >> i) & ((24'h1 << w) - 1)));
	endtask
	// Whole frame; cont skips the opcode
	task automatic xfer(input logic [7:0] op, input bit cont, input logic [23:0] addr,
		input logic [7:0] ind, input int n);
		int aw;
		int dw;
		logic [7:0] b;
		aw = op == 8'hBB ? 2 : op == 8'hEB ? 4 : 1;
		dw = op == 8'h0B ? 1 : (op == 8'h3B || op == 8'hBB) ? 2 : 4;
		got.delete();
		#9 cs_n = 1'b0;
		if (!cont) shift(op, 8, 1);
		if (op == 8'hC0) shift(ind, 8, 1);
		else begin
			shift(addr, 24, aw);
			if (aw == 4) shift(ind, 8, 4);
			repeat (aw == 1 ? 8 : 4) pulse(4'h0);
			repeat (n) begin
				for (int i = 0; i < 8; i += dw) begin
					pulse(~host_drive);
					b = 8'((b << dw) | (dw == 1 ? smp[1] : smp & 4'((1 << dw) - 1)));
				end
				got.push_back(b);
			end
		end
		cs_n = 1'b1;
		host_drive = ~host_drive;
		#63;
	endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench of the serial flash read engine
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam int AW = 10;
	logic          ref_clk = 1'b0;
	logic          resetn = 1'b0;
	logic          busy = 1'b0;
	logic          quad_enable_bit = 1'b0;
	logic          serial_clk;
	logic          cs_n;
	logic [3:0]    host_drive;
	logic [3:0]    line_level;
	logic [3:0]    data_line_out;
	logic [3:0]    data_line_oe;
	logic [AW-1:0] mem_addr;
	logic          mem_rd;
	logic [7:0]    mem_rdata = 8'h00;
	logic          cont_mode_flag;
	logic          wrap_enabled_flag;
	int            fail_count = 0;
	int            checks_done = 0;
	int            rd_count = 0;

	always #2 ref_clk = ~ref_clk;
	assign line_level = (data_line_oe & data_line_out) | (~data_line_oe & host_drive);
	// Synchronous array with a fixed pattern
	always @(posedge ref_clk) begin
		if (mem_rd) mem_rdata <= mem_addr[7:0] ^ 8'h3C;
		if (mem_rd) rd_count <= rd_count + 1;
	end

	serial_flash_read_engine #(.ADDR_W(AW)) u_dut (
		.ref_clk(ref_clk), .resetn(resetn), .busy(busy), .quad_enable_bit(quad_enable_bit),
		.serial_clk(serial_clk), .cs_n(cs_n), .data_line_in(line_level),
		.data_line_out(data_line_out), .data_line_oe(data_line_oe), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_rdata(mem_rdata), .cont_mode_flag(cont_mode_flag),
		.wrap_enabled_flag(wrap_enabled_flag)
	);
	flash_host u_host (
		.serial_clk(serial_clk), .cs_n(cs_n), .host_drive(host_drive), .line_level(line_level)
	);

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Read n bytes; m is the wrap window mask
	task automatic rd(input logic [7:0] op, input bit cont, input logic [23:0] a,
		input logic [7:0] ind, input int n, input logic [9:0] m);
		logic [9:0] e;
		u_host.xfer(op, cont, a, ind, n);
		check(8'(u_host.got.size()), 8'(n));
		for (int k = 0; k < n; k++) begin
			e = (a[9:0] & ~m) | ((a[9:0] + 10'(k)) & m);
			check(u_host.got[k], e[7:0] ^ 8'h3C);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#300000;
		fail_count++;
		end_of_test();
	end

	initial begin
		int n;
		repeat (12) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (4) @(negedge ref_clk);
		check(8'(wrap_enabled_flag), 8'h00);
		rd(8'h0B, 0, 24'hFFFFFE, 8'h00, 4, 10'h3FF);
		rd(8'h3B, 0, 24'h000123, 8'h00, 2, 10'h3FF);
		rd(8'hBB, 0, 24'h000200, 8'h00, 2, 10'h3FF);
		rd(8'h6B, 0, 24'h0000F0, 8'h00, 2, 10'h3FF);
		$display("test linear reads done");
		n = rd_count;
		@(negedge ref_clk) busy = 1'b1;
		u_host.xfer(8'h0B, 0, 24'h000010, 8'h00, 2);
		@(negedge ref_clk) busy = 1'b0;
		u_host.xfer(8'hEB, 0, 24'h000010, 8'hA5, 2);
		check(8'(rd_count - n), 8'h00);
		$display("test refused reads done");
		@(negedge ref_clk) quad_enable_bit = 1'b1;
		rd(8'hEB, 0, 24'h000040, 8'hA5, 2, 10'h3FF);
		check(8'(cont_mode_flag), 8'h01);
		rd(8'hEB, 1, 24'h000050, 8'h0F, 2, 10'h3FF);
		check(8'(cont_mode_flag), 8'h01);
		rd(8'hEB, 1, 24'h000060, 8'hAA, 2, 10'h3FF);
		check(8'(cont_mode_flag), 8'h00);
		rd(8'h0B, 0, 24'h000070, 8'h00, 1, 10'h3FF);
		rd(8'hEB, 0, 24'h000080, 8'h5A, 1, 10'h3FF);
		u_host.xfer(8'hFF, 0, 24'h000000, 8'h00, 0);
		check(8'(cont_mode_flag), 8'h00);
		rd(8'h0B, 0, 24'h000090, 8'h00, 1, 10'h3FF);
		$display("test continuous mode done");
		for (int d = 0; d < 4; d++) begin
			u_host.xfer(8'hC0, 0, 24'h000000, 8'(d), 0);
			check(8'(wrap_enabled_flag), 8'h01);
			rd(8'hEB, 0, 24'h00013D, 8'h00, 4, 10'((8 << d) - 1));
		end
		u_host.xfer(8'hC0, 0, 24'h000000, 8'h10, 0);
		check(8'(wrap_enabled_flag), 8'h00);
		rd(8'hEB, 0, 24'h00013D, 8'h00, 4, 10'h3FF);
		$display("test burst wrap done");
		end_of_test();
	end
endmodule
`default_nettype wire
